// ---- rtl/adc_defs.svh ----
`ifndef ADC_DEFS_SVH
`define ADC_DEFS_SVH

// Result word width and the shift count at which a read frame stops shifting.
`define RESULT_W        16
`define LAST_SHIFT      5'd16
// Result held after reset or power-down, and the pattern left by an abort.
`define RESULT_RESET    16'h0000
`define ABORT_CODE      16'hFF00
// Two's complement codes at the ends and middle of the input range.
`define CODE_POS_FULL   16'h7FFF
`define CODE_ZERO       16'h0000
`define CODE_NEG_FULL   16'h8000
// Longest conversion time and the cycle count derived from the clock rate.
`define CONV_TIME_NS    1100
`define CLK_PERIOD_NS   4
`define CONV_CYCLES     (`CONV_TIME_NS / `CLK_PERIOD_NS)
`define CONV_CNT_W      9
// Width of the gray-coded serial clock edge counter.
`define GRAY_W          4

`endif

// ---- rtl/adc_pkg.sv ----
package adc_pkg;

    // Converter core states, one-hot.
    typedef enum logic [4:0] {
        ST_SAMPLE  = 5'b00001,
        ST_CONVERT = 5'b00010,
        ST_WAIT    = 5'b00100,
        ST_NAP     = 5'b01000,
        ST_PDOWN   = 5'b10000
    } conv_state_t;

    // Control pins driven by the host, all asynchronous to clk.
    typedef struct packed {
        logic conversion_start_n;
        logic chip_select_n;
        logic frame_sync;
        logic power_down_pin;
    } host_pins_t;

    // Serial data pin and its output enable.
    typedef struct packed {
        logic sdo;
        logic sdo_oe;
    } serial_out_t;

endpackage

// ---- rtl/sar_adc_ctrl.sv ----
`include "adc_defs.svh"

module sar_adc_ctrl (
    input  wire logic                 clk,
    input  wire logic                 resetn,
    input  wire logic                 sclk,
    input  wire adc_pkg::host_pins_t  host_pins,
    input  wire logic [15:0]          sar_code,
    output logic                      busy,
    output logic                      nap_active,
    output logic                      powered_down,
    output adc_pkg::serial_out_t      serial_out
);
    import adc_pkg::*;

    logic [`GRAY_W-1:0]     sclk_bin_reg;
    logic [`GRAY_W-1:0]     sclk_bin_next;
    logic [`GRAY_W-1:0]     sclk_gray_reg;
    logic                   sclk_rst_n;
    host_pins_t             pins_s;
    host_pins_t             pins_d_reg;
    logic                   sclk_s;
    logic                   sclk_d_reg;
    logic [`GRAY_W-1:0]     gray_s;
    logic [`GRAY_W-1:0]     gray_d_reg;
    logic                   cs_low;
    logic                   pd;
    logic                   cs_fall;
    logic                   fs_rise;
    logic                   sclk_fall;
    logic                   sclk_rise;
    logic                   qcs_reg;
    logic                   qcs_d_reg;
    logic                   qcs_fall;
    logic                   sample_start;
    conv_state_t            state_reg;
    logic [`CONV_CNT_W-1:0] conv_cnt_reg;
    logic                   conv_done;
    logic [`RESULT_W-1:0]   result_reg;
    logic                   busy_d_reg;
    logic                   busy_fall;
    logic                   fs_mode_reg;
    logic                   spi_start;
    logic                   frame_start;
    logic                   frame_act_reg;
    logic                   fall_seen_reg;
    logic [4:0]             shifts_reg;
    logic [`RESULT_W-1:0]   word_reg;
    logic                   oe_reg;

    // Reset for the serial clock domain, brought over as a level.
    sync2 #(.WIDTH(1)) u_sync_rst (
        .clk      (sclk),
        .async_in (resetn),
        .sync_out (sclk_rst_n)
    );

    // Serial clock rising edges are counted on sclk itself, gray coded.
    assign sclk_bin_next = sclk_bin_reg + `GRAY_W'(1);
    always_ff @(posedge sclk) begin
        if (!sclk_rst_n) begin
            sclk_bin_reg  <= '0;
            sclk_gray_reg <= '0;
        end else begin
            sclk_bin_reg  <= sclk_bin_next;
            sclk_gray_reg <= sclk_bin_next ^ (sclk_bin_next >> 1);
        end
    end

    // Host pins, the serial clock level and the edge count enter clk.
    sync2 #(.WIDTH(4)) u_sync_pins (
        .clk      (clk),
        .async_in (host_pins),
        .sync_out (pins_s)
    );
    sync2 #(.WIDTH(1)) u_sync_sclk (
        .clk      (clk),
        .async_in (sclk),
        .sync_out (sclk_s)
    );
    sync2 #(.WIDTH(`GRAY_W)) u_sync_gray (
        .clk      (clk),
        .async_in (sclk_gray_reg),
        .sync_out (gray_s)
    );

    // Delayed copies of the synchronised inputs for edge detection.
    always_ff @(posedge clk) begin
        if (!resetn) begin
            pins_d_reg <= 4'hF;
            sclk_d_reg <= 1'b0;
            gray_d_reg <= '0;
        end else begin
            pins_d_reg <= pins_s;
            sclk_d_reg <= sclk_s;
            gray_d_reg <= gray_s;
        end
    end

    // Edge events seen in the clk domain.
    assign cs_low    = !pins_s.chip_select_n;
    assign pd        = pins_s.power_down_pin;
    assign cs_fall   = pins_d_reg.chip_select_n && cs_low;
    assign fs_rise   = cs_low && pins_s.frame_sync
                       && !pins_d_reg.frame_sync;
    assign sclk_fall = sclk_d_reg && !sclk_s;
    assign sclk_rise = (gray_s != gray_d_reg);

    // Conversion start latched while chip select is low.
    always_ff @(posedge clk) begin
        if (!resetn || pd) begin
            qcs_reg   <= 1'b1;
            qcs_d_reg <= 1'b1;
        end else begin
            if (cs_low) begin
                qcs_reg <= pins_s.conversion_start_n;
            end
            qcs_d_reg <= qcs_reg;
        end
    end

    assign qcs_fall     = qcs_d_reg && !qcs_reg;
    assign sample_start = pins_s.conversion_start_n && cs_low;

    // Converter core sequencing.
    always_ff @(posedge clk) begin
        if (!resetn) begin
            state_reg <= ST_WAIT;
        end else if (pd) begin
            state_reg <= ST_PDOWN;
        end else begin
            unique case (state_reg)
                ST_PDOWN: begin
                    state_reg <= ST_WAIT;
                end
                ST_SAMPLE: begin
                    if (qcs_fall) begin
                        state_reg <= ST_CONVERT;
                    end
                end
                ST_CONVERT: begin
                    if (qcs_fall) begin
                        state_reg <= ST_WAIT;
                    end else if (conv_done) begin
                        if (sample_start) begin
                            state_reg <= ST_SAMPLE;
                        end else if (!qcs_reg) begin
                            state_reg <= ST_NAP;
                        end else begin
                            state_reg <= ST_WAIT;
                        end
                    end
                end
                ST_WAIT, ST_NAP: begin
                    if (sample_start) begin
                        state_reg <= ST_SAMPLE;
                    end
                end
            endcase
        end
    end

    // Conversion timer, restarted at every conversion entry.
    always_ff @(posedge clk) begin
        if (!resetn || state_reg != ST_CONVERT) begin
            conv_cnt_reg <= '0;
        end else if (!conv_done) begin
            conv_cnt_reg <= conv_cnt_reg + `CONV_CNT_W'(1);
        end
    end

    assign conv_done = (conv_cnt_reg == `CONV_CNT_W'(`CONV_CYCLES - 1));

    // Held result: new code at the end of conversion, pattern on abort.
    always_ff @(posedge clk) begin
        if (!resetn || pd) begin
            result_reg <= `RESULT_RESET;
        end else if (state_reg == ST_CONVERT) begin
            if (qcs_fall) begin
                result_reg <= `ABORT_CODE;
            end else if (conv_done) begin
                result_reg <= sar_code;
            end
        end
    end

    // Busy history for finding its falling edge.
    always_ff @(posedge clk) begin
        if (!resetn) begin
            busy_d_reg <= 1'b0;
        end else begin
            busy_d_reg <= busy;
        end
    end

    assign busy         = (state_reg == ST_CONVERT);
    assign busy_fall    = busy_d_reg && !busy;
    assign nap_active   = (state_reg == ST_NAP);
    assign powered_down = (state_reg == ST_PDOWN);

    // Frame starts: select fall with sync high, sync rise, or busy reload.
    assign spi_start   = cs_fall && pins_s.frame_sync;
    assign frame_start = spi_start || fs_rise
                         || (busy_fall && fs_mode_reg && cs_low
                             && pins_s.frame_sync);

    // Readout mode follows the kind of the last frame start.
    always_ff @(posedge clk) begin
        if (!resetn || pd) begin
            fs_mode_reg <= 1'b0;
        end else if (fs_rise) begin
            fs_mode_reg <= 1'b1;
        end else if (spi_start) begin
            fs_mode_reg <= 1'b0;
        end
    end

    // Read frame: load the held word, wait for a falling clock edge,
    // then shift one bit per rising edge.
    always_ff @(posedge clk) begin
        if (!resetn || pd) begin
            frame_act_reg <= 1'b0;
            fall_seen_reg <= 1'b0;
            shifts_reg    <= 5'd0;
            word_reg      <= `RESULT_RESET;
        end else if (frame_start) begin
            frame_act_reg <= 1'b1;
            fall_seen_reg <= 1'b0;
            shifts_reg    <= 5'd0;
            word_reg      <= result_reg;
        end else if (!cs_low) begin
            frame_act_reg <= 1'b0;
        end else if (frame_act_reg) begin
            if (sclk_fall && !(fs_mode_reg && pins_s.frame_sync)) begin
                fall_seen_reg <= 1'b1;
            end
            if (sclk_rise && fall_seen_reg
                && shifts_reg != `LAST_SHIFT) begin
                shifts_reg <= shifts_reg + 5'd1;
                word_reg   <= {word_reg[`RESULT_W-2:0], 1'b0};
            end
        end
    end

    // Serial pin is driven while selected and not powered down.
    always_ff @(posedge clk) begin
        if (!resetn) begin
            oe_reg <= 1'b0;
        end else begin
            oe_reg <= cs_low && !pd;
        end
    end

    assign serial_out.sdo    = word_reg[`RESULT_W-1];
    assign serial_out.sdo_oe = oe_reg;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!resetn);

    // Busy only rises on a qualified start fall while sampling.
    AST_BUSY_RISE: assert property (
        $rose(busy) |-> $past(qcs_fall) && $past(state_reg == ST_SAMPLE))
        else $error("Busy rose without a start from sampling.");

    // Qualified start holds while chip select is high.
    AST_QCS_HOLD: assert property (
        (pins_s.chip_select_n && !pd) |=> qcs_reg == $past(qcs_reg))
        else $error("Qualified start moved with chip select high.");

    // Chip select high ends any frame.
    AST_FRAME_CS: assert property (
        (!cs_low && !fs_rise && !pd) |=> !frame_act_reg)
        else $error("Frame stayed active with chip select high.");

    // Power-down takes the core down and clears busy.
    AST_PDOWN: assert property (
        pd |=> state_reg == ST_PDOWN && !busy && !frame_act_reg)
        else $error("Power-down did not reset the core.");

    // Sample start from wait or nap enters sampling.
    AST_SAMPLE: assert property (
        ((state_reg == ST_WAIT || state_reg == ST_NAP)
         && sample_start && !pd) |=> state_reg == ST_SAMPLE)
        else $error("Sample start ignored in wait or nap.");

    // Back-to-back conversion goes straight to sampling.
    AST_B2B: assert property (
        (busy && conv_done && !qcs_fall && sample_start && !pd)
        |=> state_reg == ST_SAMPLE && !busy)
        else $error("No direct sampling after conversion.");

    // Conversion end with start low enters nap.
    AST_NAP: assert property (
        (busy && conv_done && !qcs_fall && !sample_start && !qcs_reg
         && !pd) |=> nap_active)
        else $error("Nap not entered at conversion end.");

    // Abort enters wait with the abort pattern held.
    AST_ABORT: assert property (
        (busy && qcs_fall && !pd)
        |=> state_reg == ST_WAIT && result_reg == `ABORT_CODE)
        else $error("Abort did not reach wait with pattern.");

    // The held result is untouched during a conversion.
    AST_RES_STABLE: assert property (
        (busy && !conv_done && !qcs_fall && !pd)
        |=> result_reg == $past(result_reg))
        else $error("Result changed during conversion.");

    // A frame start presents the held result from its MSB.
    AST_FRAME_LOAD: assert property (
        (frame_start && !pd)
        |=> word_reg == $past(result_reg) && shifts_reg == 5'd0
            && !fall_seen_reg)
        else $error("Frame start did not reload the word.");

    // Frame sync high at busy fall reloads the new result.
    AST_FS_RELOAD: assert property (
        (busy_fall && fs_mode_reg && cs_low && pins_s.frame_sync && !pd)
        |=> word_reg == $past(result_reg) && shifts_reg == 5'd0)
        else $error("Busy fall did not reload in sync mode.");

    // No shift happens before a falling clock edge in the frame.
    AST_NO_EARLY: assert property (
        (frame_act_reg && !fall_seen_reg && !frame_start && !pd)
        |=> shifts_reg == $past(shifts_reg))
        else $error("Shift before the first falling edge.");

endmodule // sar_adc_ctrl

// ---- rtl/sync2.sv ----
module sync2 #(
    parameter int WIDTH = 1
) (
    input  wire logic             clk,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta_reg;

    // Two flip-flops; only the second stage is read outside.
    always_ff @(posedge clk) begin
        meta_reg <= async_in;
        sync_out <= meta_reg;
    end

endmodule // sync2

// ---- verif/host_model.sv ----
module host_model (
    output adc_pkg::host_pins_t       pins,
    output logic                      sclk,
    input  wire adc_pkg::serial_out_t so
);
    timeunit 1ns;
    timeprecision 100ps;
    import adc_pkg::*;
    localparam int HALF = 24;
    logic last_bit = 1'h0;
    // A released data line shows the inverse of its last bit.
    wire  sdo_line = so.sdo_oe ? so.sdo : ~last_bit;

    // Idle host: deselected, frame sync high, clock high.
    initial begin
        pins = 4'hE;
        sclk = 1'h1;
    end

    // Sets conversion start, chip select, frame sync and power-down.
    task automatic drive(input logic [3:0] v);
        pins = v;
    endtask

    // Toggles the clock while deselected so link-side flops see reset.
    task automatic idle_clocks(input int n, input int half);
        repeat (n) begin
            #half sclk = 1'h0;
            #half sclk = 1'h1;
        end
    endtask

    // A full high and low half arms the frame, so no edge is too short
    // to be seen; then each rise shifts a bit taken mid-low.
    task automatic shift(input int n, inout logic [15:0] w);
        sclk = 1'h1;
        #HALF sclk = 1'h0;
        #HALF;
        repeat (n) begin
            sclk = 1'h1;
            #HALF sclk = 1'h0;
            #(HALF / 2) w = {w[14:0], sdo_line};
            last_bit = sdo_line;
            #(HALF / 2);
        end
    endtask

    // Read framed by chip select with frame sync held high; select is
    // raised first so that every call opens a fresh frame.
    task automatic spi_read(input int n, output logic [15:0] w);
        pins.frame_sync = 1'h1;
        pins.chip_select_n = 1'h1;
        #40 pins.chip_select_n = 1'h0;
        #40 w = {15'h0, sdo_line};
        shift(n, w);
        pins.chip_select_n = 1'h1;
        #40;
    endtask

    // Read framed by a frame sync pulse while chip select stays low.
    task automatic fs_read(input int n, output logic [15:0] w);
        pins.frame_sync = 1'h1;
        #40 w = {15'h0, sdo_line};
        pins.frame_sync = 1'h0;
        #40 shift(n, w);
    endtask
endmodule // host_model

// ---- verif/sar_adc_ctrl_bench.sv ----
`include "adc_defs.svh"

module sar_adc_ctrl_bench;
    timeunit 1ns;
    timeprecision 100ps;
    import adc_pkg::*;
    logic        clk      = 1'h0;
    logic        resetn   = 1'h0;
    logic [15:0] sar_code;
    logic [15:0] code_tgt = 16'h0;
    logic [15:0] w;
    wire         busy;
    wire         nap_active;
    wire         powered_down;
    wire         sclk;
    wire host_pins_t  pins;
    wire serial_out_t so;
    int          fails    = 0;
    int          n_checks = 0;

    // The core clock runs at 250 MHz.
    always #2 clk = ~clk;

    // The array code settles to the target only while a conversion runs,
    // so a result taken at the wrong cycle shows the inverse.
    always @(posedge clk) begin
        #1 sar_code = busy ? code_tgt : ~code_tgt;
    end

    sar_adc_ctrl sar_adc_ctrl_i (.clk(clk), .resetn(resetn), .sclk(sclk),
        .host_pins(pins), .sar_code(sar_code), .busy(busy),
        .nap_active(nap_active), .powered_down(powered_down),
        .serial_out(so));
    host_model host_model_i (.pins(pins), .sclk(sclk), .so(so));

    // Counts a comparison and reports a mismatch.
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fails++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time,
                     seen, exp);
        end
    endtask

    // Lands just after the n-th rising edge from now.
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    // Waits up to n cycles for busy to reach a level; t counts them.
    task automatic wait_busy(input logic lvl, input int n, output int t);
        t = 0;
        while (busy !== lvl && t < n) begin
            tick(1);
            t++;
        end
    endtask

    // Gives the sample start, then drops start to launch a conversion.
    task automatic start_conv();
        int t;
        host_model_i.drive(4'hA);
        tick(8);
        host_model_i.drive(4'h2);
        wait_busy(1'h1, 12, t);
        check(busy, 16'h1);
    endtask

    // An end with start low naps; the read returns the new code.
    task automatic t_nap();
        int t;
        check({busy, nap_active, powered_down, so.sdo_oe}, 16'h0);
        code_tgt = `CODE_POS_FULL;
        start_conv();
        wait_busy(1'h0, 300, t);
        check(16'(t), 16'(`CONV_CYCLES));
        tick(2);
        check(nap_active, 16'h1);
        host_model_i.spi_read(15, w);
        check(w, `CODE_POS_FULL);
        host_model_i.drive(4'hA);
        tick(8);
        check(nap_active, 16'h0);
        $display("test nap done");
    endtask

    // Start high at the end samples at once; mid-run reads show old data.
    task automatic t_back();
        int t;
        code_tgt = `CODE_NEG_FULL;
        host_model_i.drive(4'h2);
        wait_busy(1'h1, 12, t);
        host_model_i.drive(4'hA);
        host_model_i.spi_read(15, w);
        check(w, `CODE_POS_FULL);
        check(busy, 16'h1);
        host_model_i.drive(4'hA);
        wait_busy(1'h0, 100, t);
        tick(2);
        check({busy, nap_active}, 16'h0);
        host_model_i.drive(4'h2);
        wait_busy(1'h1, 12, t);
        check(busy, 16'h1);
        $display("test back to back done");
    endtask

    // A second start fall aborts the run and leaves the abort pattern.
    task automatic t_abort();
        int t;
        host_model_i.spi_read(15, w);
        check(w, `CODE_NEG_FULL);
        host_model_i.drive(4'hA);
        tick(4);
        host_model_i.drive(4'h2);
        wait_busy(1'h0, 20, t);
        check(busy, 16'h0);
        tick(2);
        check(nap_active, 16'h0);
        host_model_i.spi_read(4, w);
        host_model_i.spi_read(15, w);
        check(w, `ABORT_CODE);
        $display("test abort done");
    endtask

    // Deselected, start, frame sync and clock do nothing.
    task automatic t_qual();
        host_model_i.drive(4'hE);
        tick(8);
        host_model_i.drive(4'h6);
        tick(8);
        check(busy, 16'h0);
        host_model_i.drive(4'h4);
        tick(4);
        host_model_i.drive(4'h6);
        host_model_i.shift(4, w);
        check(so.sdo_oe, 16'h0);
        check(so.sdo, 16'h0);
        $display("test qualification done");
    endtask

    // Frame sync frames restart on a new pulse and reload at busy fall.
    task automatic t_fs();
        int t;
        host_model_i.drive(4'h0);
        tick(8);
        host_model_i.fs_read(4, w);
        host_model_i.fs_read(15, w);
        check(w, `ABORT_CODE);
        code_tgt = 16'h1234;
        start_conv();
        tick(8);
        check(so.sdo, 16'h1);
        wait_busy(1'h0, 300, t);
        tick(3);
        check(so.sdo, 16'h0);
        host_model_i.drive(4'h0);
        tick(8);
        w = {15'h0, so.sdo};
        host_model_i.shift(15, w);
        check(w, 16'h1234);
        $display("test frame sync done");
    endtask

    // Power-down mid-run clears busy, releases the pin and the result.
    task automatic t_pd();
        start_conv();
        host_model_i.drive(4'h7);
        tick(5);
        check({powered_down, busy, so.sdo_oe}, 16'h4);
        host_model_i.drive(4'h6);
        tick(8);
        check(powered_down, 16'h0);
        host_model_i.spi_read(15, w);
        check(w, `RESULT_RESET);
        $display("test power down done");
    endtask

    // Prints the counts and the verdict, then ends the run.
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // Main sequence; the link clock runs on past reset until its own
    // synchronised reset has landed, then stands still.
    initial begin
        fork
            host_model_i.idle_clocks(4, 24);
        join_none
        tick(16);
        resetn = 1'h1;
        tick(40);
        t_nap();
        t_back();
        t_abort();
        t_qual();
        t_fs();
        t_pd();
        print_verdict();
    end

    // Cuts a hang short well past the expected run of about 10 us.
    initial begin
        #100000;
        fails++;
        print_verdict();
    end
endmodule // sar_adc_ctrl_bench
